/* File: hbfs_pkg.sv */
package hbfs_pkg;
  // Bridge count and filter timing
  localparam int NUM_HB = 3;
  localparam int CLK_MHZ = 125;
  localparam int OC_FILTER_US = 10;
  localparam int OL_FILTER_US = 2000;
  localparam int DEAD_TIME_NS = 200;
  localparam int OC_FILTER_CYC = OC_FILTER_US * CLK_MHZ;
  localparam int OL_FILTER_CYC = OL_FILTER_US * CLK_MHZ;
  localparam int DEAD_TIME_CYC = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 20;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_GSTAT = 8'h04;
  localparam logic [7:0] ADDR_OC = 8'h08;
  localparam logic [7:0] ADDR_OL = 8'h0c;
  localparam logic [7:0] ADDR_OP = 8'h10;

  // Global status bit positions
  localparam int GS_TPW = 1;
  localparam int GS_TSD = 2;
  localparam int GS_OV = 4;
  localparam int GS_UV = 5;
  localparam int GS_LE = 6;
  localparam int GS_RESET_INDICATOR_N = 0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Half-bridge side sequencer states
  typedef enum logic [1:0] {
    HBFS_OFF = 2'b00,
    HBFS_HS = 2'b01,
    HBFS_DEAD = 2'b11,
    HBFS_LS = 2'b10
  } hbfs_side_t;
endpackage : hbfs_pkg

/* File: hbfs_bridge.sv */
`timescale 1ns/1ns
module hbfs_bridge #(
  parameter int OC_CYC = hbfs_pkg::OC_FILTER_CYC,
  parameter int OL_CYC = hbfs_pkg::OL_FILTER_CYC,
  parameter int DT_CYC = hbfs_pkg::DEAD_TIME_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic hs_req,
  input wire logic ls_req,
  input wire logic global_off,
  input wire logic [1:0] oc_blocked,
  // Monitors, index 0 high side, 1 low side
  input wire logic [1:0] oc_mon,
  input wire logic [1:0] ol_mon,
  // Results
  output logic hs_on,
  output logic ls_on,
  output logic [1:0] oc_event,
  output logic [1:0] ol_event
);
  initial begin
    if (OC_CYC < 1 || OL_CYC < 1 || DT_CYC < 1 || OL_CYC >= (1 << hbfs_pkg::CNT_W)) begin
      $error("hbfs_bridge: bad filter or dead time count");
    end
  end

  typedef struct packed {
    hbfs_pkg::hbfs_side_t side;
    hbfs_pkg::hbfs_side_t target;
    logic [hbfs_pkg::CNT_W-1:0] dt_cnt;
    logic [1:0][hbfs_pkg::CNT_W-1:0] oc_cnt;
    logic [1:0][hbfs_pkg::CNT_W-1:0] ol_cnt;
    logic [1:0] oc_ev;
    logic [1:0] ol_ev;
  } hbfs_br_state_t;

  hbfs_br_state_t st_reg;
  hbfs_br_state_t st_next;
  logic want_hs;
  logic want_ls;
  hbfs_pkg::hbfs_side_t want;

  always_comb begin
    st_next = st_reg;
    // High side wins if both are requested; never both on
    want_hs = hs_req && !global_off && !oc_blocked[0]; // [RQ2] [RQ3]
    want_ls = ls_req && !hs_req && !global_off && !oc_blocked[1]; // [RQ3]
    want = want_hs ? hbfs_pkg::HBFS_HS : (want_ls ? hbfs_pkg::HBFS_LS : hbfs_pkg::HBFS_OFF);
    st_next.oc_ev = 2'h0;
    st_next.ol_ev = 2'h0;
    case (st_reg.side)
      hbfs_pkg::HBFS_OFF: begin
        if (want != hbfs_pkg::HBFS_OFF) begin
          st_next.side = hbfs_pkg::HBFS_DEAD; // [RQ4]
          st_next.target = want;
          st_next.dt_cnt = '0;
        end
      end
      hbfs_pkg::HBFS_HS, hbfs_pkg::HBFS_LS: begin
        if (want != st_reg.side) begin
          st_next.side = hbfs_pkg::HBFS_OFF;
        end
      end
      hbfs_pkg::HBFS_DEAD: begin
        // Both sides off while the gap elapses
        if (want != st_reg.target) begin
          st_next.side = hbfs_pkg::HBFS_OFF;
        end else if (st_reg.dt_cnt >= hbfs_pkg::CNT_W'(DT_CYC - 1)) begin
          st_next.side = st_reg.target; // [RQ4]
        end else begin
          st_next.dt_cnt = st_reg.dt_cnt + 1'b1;
        end
      end
      default: st_next.side = hbfs_pkg::HBFS_OFF;
    endcase
    for (int i = 0; i < 2; i++) begin
      // Filters restart whenever the condition drops early
      if (st_reg.side == (i == 0 ? hbfs_pkg::HBFS_HS : hbfs_pkg::HBFS_LS) && oc_mon[i]) begin
        if (st_reg.oc_cnt[i] >= hbfs_pkg::CNT_W'(OC_CYC - 1)) begin
          st_next.oc_ev[i] = 1'b1; // [RQ1]
          st_next.oc_cnt[i] = '0;
        end else begin
          st_next.oc_cnt[i] = st_reg.oc_cnt[i] + 1'b1; // [RQ20]
        end
      end else begin
        st_next.oc_cnt[i] = '0; // [RQ20]
      end
      if (st_reg.side == (i == 0 ? hbfs_pkg::HBFS_HS : hbfs_pkg::HBFS_LS) && ol_mon[i]) begin
        if (st_reg.ol_cnt[i] >= hbfs_pkg::CNT_W'(OL_CYC - 1)) begin
          st_next.ol_ev[i] = 1'b1; // [RQ17]
        end else begin
          st_next.ol_cnt[i] = st_reg.ol_cnt[i] + 1'b1; // [RQ20]
        end
      end else begin
        st_next.ol_cnt[i] = '0; // [RQ20]
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hs_on = (st_reg.side == hbfs_pkg::HBFS_HS);
  assign ls_on = (st_reg.side == hbfs_pkg::HBFS_LS);
  assign oc_event = st_reg.oc_ev;
  assign ol_event = st_reg.ol_ev;
endmodule : hbfs_bridge

/* File: hbfs_top.sv */
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
// Functional notes
// RQ1: Overcurrent turns the switch off, control bit stays 1, flag and load error set.
// RQ2: Overcurrent switch stays off while its latched flag is set.
// RQ3: High and low side of one bridge are never on together.
// RQ4: A dead time separates turning one side off and the other on.
// RQ5: Warning temperature sets the warning flag; outputs stay active.
// RQ6: Warning flag is latched and cleared only by a bus access.
// RQ7: Shutdown temperature latches all outputs off and sets shutdown flag.
// RQ8: Outputs stay off until the shutdown flag is cleared.
// RQ9: Control bits read 1 during overtemperature; flags clear only as described.
// RQ10: Host clears shutdown flag to resume or recheck.
// RQ11: Supply undervoltage turns stages off, latches flag, keeps registers intact.
// RQ12: Stages resume by themselves when supply recovers; host clears the flag.
// RQ13: Supply overvoltage turns stages off and latches its flag.
// RQ14: Stages resume when overvoltage ends; host clears the flag.
// RQ15: Logic-supply reset initializes all state and floats all outputs.
// RQ16: Reset indicator reads 0 after reset once in normal mode.
// RQ17: Open load past filter time latches flag and load error; output stays on.
// RQ18: Host clears open-load flag to see if it persists.
// RQ19: Read with operation bit 1 reads then clears; with 0 only reads.
// RQ20: Overcurrent and open-load filters are counters restarting on early release.
// RQ21: Load error is the OR of all latched overcurrent and open-load flags.
module hbfs_top #(
  parameter int NUM_HB = hbfs_pkg::NUM_HB,
  parameter int OC_CYC = hbfs_pkg::OC_FILTER_CYC,
  parameter int OL_CYC = hbfs_pkg::OL_FILTER_CYC,
  parameter int DT_CYC = hbfs_pkg::DEAD_TIME_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog monitors, asynchronous
  input wire logic wake_pin,
  input wire logic [NUM_HB-1:0] hs_overcurrent,
  input wire logic [NUM_HB-1:0] ls_overcurrent,
  input wire logic [NUM_HB-1:0] hs_open_load,
  input wire logic [NUM_HB-1:0] ls_open_load,
  input wire logic temp_warning,
  input wire logic temp_shutdown,
  input wire logic supply_under,
  input wire logic supply_over,
  // Power stage gates, enable low means high impedance
  output logic [NUM_HB-1:0] hs_gate,
  output logic [NUM_HB-1:0] ls_gate,
  output logic [NUM_HB-1:0] stage_enable
);
  localparam int NMON = 4 * NUM_HB + 5;

  initial begin
    if (NUM_HB < 1 || NUM_HB > 8) begin
      $error("hbfs_top: NUM_HB must be 1 to 8");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic [2:0][NMON-1:0] sync;
    logic [NMON-1:0] mon;
    logic [NUM_HB-1:0] hs_act;
    logic [NUM_HB-1:0] ls_act;
    logic clear_on_read;
    logic [NUM_HB-1:0] hs_oc;
    logic [NUM_HB-1:0] ls_oc;
    logic [NUM_HB-1:0] hs_ol;
    logic [NUM_HB-1:0] ls_ol;
    logic thermal_warning_flag;
    logic thermal_shutdown_flag;
    logic uv;
    logic ov;
    logic reset_indicator_n;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [NUM_HB-1:0] hs_gate;
    logic [NUM_HB-1:0] ls_gate;
    logic [NUM_HB-1:0] stage_en;
  } hbfs_state_t;

  hbfs_state_t st_reg;
  hbfs_state_t st_next;

  logic [NUM_HB-1:0] hs_on;
  logic [NUM_HB-1:0] ls_on;
  logic [NUM_HB-1:0][1:0] oc_ev;
  logic [NUM_HB-1:0][1:0] ol_ev;
  logic global_off;
  logic load_err;
  logic [NMON-1:0] raw_mon;

  assign raw_mon = {wake_pin, supply_over, supply_under, temp_shutdown, temp_warning,
                    ls_open_load, hs_open_load, ls_overcurrent, hs_overcurrent};

  // Output stages off on any global fault; undervoltage and overvoltage recover by themselves
  assign global_off = st_reg.thermal_shutdown_flag | st_reg.mon[NMON-4] | st_reg.mon[NMON-2]
                      | st_reg.mon[NMON-3]; // [RQ8] [RQ11] [RQ12] [RQ13] [RQ14]
  assign load_err = |{st_reg.hs_oc, st_reg.ls_oc, st_reg.hs_ol, st_reg.ls_ol}; // [RQ21]

  ////////////////////////////////////////////////////////////////////////////
  // Per-bridge sequencing and filters
  for (genvar g = 0; g < NUM_HB; g++) begin : gen_hb
    hbfs_bridge #(
      .OC_CYC(OC_CYC),
      .OL_CYC(OL_CYC),
      .DT_CYC(DT_CYC)
    ) u_bridge (
      .aclk(aclk),
      .aresetn(aresetn),
      .hs_req(st_reg.hs_act[g]),
      .ls_req(st_reg.ls_act[g]),
      .global_off(global_off),
      .oc_blocked({st_reg.ls_oc[g], st_reg.hs_oc[g]}),
      .oc_mon({st_reg.mon[NUM_HB + g], st_reg.mon[g]}),
      .ol_mon({st_reg.mon[3 * NUM_HB + g], st_reg.mon[2 * NUM_HB + g]}),
      .hs_on(hs_on[g]),
      .ls_on(ls_on[g]),
      .oc_event(oc_ev[g]),
      .ol_event(ol_ev[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [31:0] rd;
    logic [1:0] rr;
    logic [7:0] ra;
    logic rd_clear;
    rd = '0;
    rr = hbfs_pkg::RESP_OKAY;
    ra = s_axi_araddr;
    rd_clear = 1'b0;
    st_next = st_reg;

    // Three-stage synchroniser; a change counts when stages two and three agree
    st_next.sync = {st_reg.sync[1:0], raw_mon};
    for (int i = 0; i < NMON; i++) begin
      if (st_reg.sync[1][i] == st_reg.sync[2][i]) begin
        st_next.mon[i] = st_reg.sync[2][i];
      end
    end

    // Gates follow the sequencers; stages float only in reset
    st_next.hs_gate = hs_on;
    st_next.ls_gate = ls_on;
    st_next.stage_en = {NUM_HB{1'b1}}; // [RQ15]

    // Write channel: address and data in either order
    if (s_axi_awvalid && st_reg.awready) begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr;
      st_next.awready = 1'b0;
    end
    if (s_axi_wvalid && st_reg.wready) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb = s_axi_wstrb;
      st_next.wready = 1'b0;
    end
    if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = hbfs_pkg::RESP_OKAY;
      case (st_reg.awaddr)
        hbfs_pkg::ADDR_CTRL: begin
          if (st_reg.wstrb[0]) begin
            st_next.hs_act = st_reg.wdata[NUM_HB-1:0];
          end
          if (st_reg.wstrb[1]) begin
            st_next.ls_act = st_reg.wdata[8 +: NUM_HB];
          end
        end
        hbfs_pkg::ADDR_OP: begin
          if (st_reg.wstrb[0]) begin
            st_next.clear_on_read = st_reg.wdata[0];
          end
        end
        hbfs_pkg::ADDR_GSTAT, hbfs_pkg::ADDR_OC, hbfs_pkg::ADDR_OL: ;
        default: st_next.bresp = hbfs_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
      st_next.awready = 1'b1;
      st_next.wready = 1'b1;
    end

    // Read channel
    if (s_axi_arvalid && st_reg.arready) begin
      st_next.arready = 1'b0;
      st_next.rvalid = 1'b1;
      case (ra)
        // Control bits keep reading as written through any fault
        hbfs_pkg::ADDR_CTRL: begin
          rd[NUM_HB-1:0] = st_reg.hs_act; // [RQ1] [RQ9]
          rd[8 +: NUM_HB] = st_reg.ls_act;
        end
        hbfs_pkg::ADDR_GSTAT: begin
          rd[hbfs_pkg::GS_LE] = load_err; // [RQ1] [RQ21]
          rd[hbfs_pkg::GS_TPW] = st_reg.thermal_warning_flag;
          rd[hbfs_pkg::GS_TSD] = st_reg.thermal_shutdown_flag;
          rd[hbfs_pkg::GS_UV] = st_reg.uv;
          rd[hbfs_pkg::GS_OV] = st_reg.ov;
          rd[hbfs_pkg::GS_RESET_INDICATOR_N] = st_reg.reset_indicator_n; // [RQ16]
          rd_clear = st_reg.clear_on_read;
        end
        hbfs_pkg::ADDR_OC: begin
          rd[NUM_HB-1:0] = st_reg.hs_oc;
          rd[8 +: NUM_HB] = st_reg.ls_oc;
          rd_clear = st_reg.clear_on_read;
        end
        hbfs_pkg::ADDR_OL: begin
          rd[NUM_HB-1:0] = st_reg.hs_ol;
          rd[8 +: NUM_HB] = st_reg.ls_ol;
          rd_clear = st_reg.clear_on_read;
        end
        hbfs_pkg::ADDR_OP: begin
          rd[0] = st_reg.clear_on_read;
        end
        default: rr = hbfs_pkg::RESP_SLVERR;
      endcase
      st_next.rdata = rd;
      st_next.rresp = rr;
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
      st_next.arready = 1'b1;
    end

    // Read and clear, only the register just read; sets below win
    if (rd_clear) begin // [RQ19] [RQ10] [RQ18] [RQ6]
      case (ra)
        hbfs_pkg::ADDR_GSTAT: begin
          st_next.thermal_warning_flag = 1'b0;
          st_next.thermal_shutdown_flag = 1'b0;
          st_next.uv = 1'b0;
          st_next.ov = 1'b0;
          st_next.reset_indicator_n = 1'b1;
        end
        hbfs_pkg::ADDR_OC: begin
          st_next.hs_oc = '0;
          st_next.ls_oc = '0;
        end
        default: begin
          st_next.hs_ol = '0;
          st_next.ls_ol = '0;
        end
      endcase
    end

    // Fault latches; a present condition sets again at once
    for (int g = 0; g < NUM_HB; g++) begin
      if (oc_ev[g][0]) st_next.hs_oc[g] = 1'b1; // [RQ1] [RQ2]
      if (oc_ev[g][1]) st_next.ls_oc[g] = 1'b1; // [RQ1]
      if (ol_ev[g][0]) st_next.hs_ol[g] = 1'b1; // [RQ17]
      if (ol_ev[g][1]) st_next.ls_ol[g] = 1'b1; // [RQ17]
    end
    if (st_reg.mon[NMON-5]) st_next.thermal_warning_flag = 1'b1; // [RQ5] [RQ9]
    if (st_reg.mon[NMON-4]) st_next.thermal_shutdown_flag = 1'b1; // [RQ7]
    if (st_reg.mon[NMON-3]) st_next.uv = 1'b1; // [RQ11]
    if (st_reg.mon[NMON-2]) st_next.ov = 1'b1; // [RQ13]
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0; // [RQ15]
      st_reg.awready <= 1'b1;
      st_reg.wready <= 1'b1;
      st_reg.arready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready = st_reg.wready;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign hs_gate = st_reg.hs_gate;
  assign ls_gate = st_reg.ls_gate;
  assign stage_enable = st_reg.stage_en;
endmodule : hbfs_top

/* File: hbfs_checker.sv */
`timescale 1ns/1ns
module hbfs_checker #(
  parameter int NUM_HB = 3
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Monitors
  input wire logic [NUM_HB-1:0] hs_overcurrent,
  input wire logic temp_shutdown,
  input wire logic supply_under,
  input wire logic supply_over,
  // Power stages
  input wire logic [NUM_HB-1:0] hs_gate,
  input wire logic [NUM_HB-1:0] ls_gate,
  input wire logic [NUM_HB-1:0] stage_enable
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////
  a_no_cross: assert property (!(|(hs_gate & ls_gate)))
    else $error("both sides on");
  a_dead_hs: assert property ($rose(hs_gate[0]) |->
    !$past(ls_gate[0]) && !$past(ls_gate[0], 2)) else $error("no gap before high side");
  a_dead_ls: assert property ($rose(ls_gate[0]) |->
    !$past(hs_gate[0]) && !$past(hs_gate[0], 2)) else $error("no gap before low side");
  // Eight cycles cover the monitor synchroniser plus the gate register
  a_uv_off: assert property (supply_under [*8] |-> hs_gate == '0 && ls_gate == '0)
    else $error("gates on in undervoltage");
  a_ov_off: assert property (supply_over [*8] |-> hs_gate == '0 && ls_gate == '0)
    else $error("gates on in overvoltage");
  a_tsd_off: assert property (temp_shutdown [*8] |-> hs_gate == '0 && ls_gate == '0)
    else $error("gates on in thermal shutdown");
  a_oc_off: assert property (hs_overcurrent[0] [*8] |-> ##[0:8] !hs_gate[0])
    else $error("overcurrent switch kept on");
  a_rst_float: assert property ($rose(aresetn) |-> stage_enable == '0)
    else $error("stages driven in reset");
  a_stage_up: assert property (aresetn [*3] |-> &stage_enable)
    else $error("stages not enabled");
endmodule : hbfs_checker

bind hbfs_top hbfs_checker #(.NUM_HB(NUM_HB)) hbfs_checker_inst (.aclk(aclk),
  .aresetn(aresetn), .hs_overcurrent(hs_overcurrent), .temp_shutdown(temp_shutdown),
  .supply_under(supply_under), .supply_over(supply_over), .hs_gate(hs_gate),
  .ls_gate(ls_gate), .stage_enable(stage_enable));

/* File: hbfs_load.sv */
`timescale 1ns/1ns
module hbfs_load #(
  parameter int N = 3
) (
  // Gates from the driver
  input wire logic [N-1:0] hs_gate,
  input wire logic [N-1:0] ls_gate,
  // Fault injection
  input wire logic [N-1:0] hs_short,
  input wire logic [N-1:0] ls_short,
  input wire logic [N-1:0] hs_open,
  input wire logic [N-1:0] ls_open,
  // Current monitors
  output logic [N-1:0] hs_overcurrent,
  output logic [N-1:0] ls_overcurrent,
  output logic [N-1:0] hs_open_load,
  output logic [N-1:0] ls_open_load
);
  // Current only flows through a switch that is on, so faults vanish once it is off
  assign hs_overcurrent = hs_gate & hs_short;
  assign ls_overcurrent = ls_gate & ls_short;
  assign hs_open_load = hs_gate & hs_open;
  assign ls_open_load = ls_gate & ls_open;
endmodule : hbfs_load

/* File: tb_hbfs_top.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_hbfs_top;
  localparam int N = 3;
  typedef struct packed {
    logic [3:0] mon;
    logic on_dur;
    logic on_aft;
    logic [7:0] gs;
  } hbfs_row_t;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [3:0] mon = 4'h0;
  logic [N-1:0] hs_short = 3'h0;
  logic [N-1:0] ls_short = 3'h0;
  logic [N-1:0] ls_open = 3'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, q;
  logic [N-1:0] hs_overcurrent, ls_overcurrent, hs_open_load, ls_open_load;
  logic [N-1:0] hs_gate, ls_gate, stage_enable;
  int num_errors = 0;
  int comparisons = 0;
  // Monitor order: warning, shutdown, under, over
  hbfs_row_t rows [4] = '{'{4'h1, 1'h1, 1'h1, 8'h03}, '{4'h2, 1'h0, 1'h0, 8'h05},
    '{4'h4, 1'h0, 1'h1, 8'h21}, '{4'h8, 1'h0, 1'h1, 8'h11}};

  always #4 aclk = ~aclk;

  hbfs_top #(.OC_CYC(4), .OL_CYC(8), .DT_CYC(2)) hbfs_top_inst (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .wake_pin(1'h1), .hs_overcurrent, .ls_overcurrent,
    .hs_open_load, .ls_open_load, .temp_warning(mon[0]), .temp_shutdown(mon[1]),
    .supply_under(mon[2]), .supply_over(mon[3]), .hs_gate, .ls_gate, .stage_enable);
  hbfs_load #(.N(N)) hbfs_load_inst (.hs_gate, .ls_gate, .hs_short, .ls_short,
    .hs_open(3'h0), .ls_open, .hs_overcurrent, .ls_overcurrent, .hs_open_load,
    .ls_open_load);

  //////////////////////////////////////////////////////////////
  task automatic wt(input int c);
    repeat (c) @(posedge aclk);
  endtask : wt

  task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    if (wr) begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_bready && s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
      if (s_axi_rready && s_axi_rvalid) begin
        r = s_axi_rresp;
        q = s_axi_rdata;
        s_axi_rready <= 1'h0;
        break;
      end
    end
  endtask : axi

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    axi(1'h0, a, 32'h0);
    `CHK("rdata", e, q)
  endtask : rd

  task automatic conclude();
    if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude

  initial begin
    wt(6000);
    num_errors++;
    conclude();
  end

  //////////////////////////////////////////////////////////////
  initial begin
    wt(4);
    aresetn <= 1'h1;
    wt(3);
    rd(hbfs_pkg::ADDR_GSTAT, 32'h0);
    `CHK("stage_en", 3'h7, stage_enable)
    axi(1'h1, hbfs_pkg::ADDR_OP, 32'h1);
    rd(hbfs_pkg::ADDR_GSTAT, 32'h0);
    rd(hbfs_pkg::ADDR_GSTAT, 32'h1);
    axi(1'h1, hbfs_pkg::ADDR_CTRL, 32'h1);
    wt(12);
    foreach (rows[i]) begin
      mon <= rows[i].mon;
      wt(12);
      `CHK("gate_dur", rows[i].on_dur, hs_gate[0])
      mon <= 4'h0;
      wt(12);
      `CHK("gate_aft", rows[i].on_aft, hs_gate[0])
      rd(hbfs_pkg::ADDR_CTRL, 32'h1);
      rd(hbfs_pkg::ADDR_GSTAT, {24'h0, rows[i].gs});
      rd(hbfs_pkg::ADDR_GSTAT, 32'h1);
      wt(12);
      `CHK("gate_clr", 1'h1, hs_gate[0])
    end
    // Overcurrent trips, stays off until its flag is cleared
    hs_short <= 3'h1;
    wt(14);
    `CHK("oc_gate", 1'h0, hs_gate[0])
    hs_short <= 3'h0;
    axi(1'h1, hbfs_pkg::ADDR_OP, 32'h0);
    rd(hbfs_pkg::ADDR_GSTAT, 32'h41);
    rd(hbfs_pkg::ADDR_CTRL, 32'h1);
    wt(12);
    `CHK("oc_hold", 1'h0, hs_gate[0])
    rd(hbfs_pkg::ADDR_OC, 32'h1);
    axi(1'h1, hbfs_pkg::ADDR_OP, 32'h1);
    rd(hbfs_pkg::ADDR_OC, 32'h1);
    wt(12);
    `CHK("oc_back", 1'h1, hs_gate[0])
    rd(hbfs_pkg::ADDR_GSTAT, 32'h1);
    // Side swap, then a short open-load glitch that must not latch
    axi(1'h1, hbfs_pkg::ADDR_CTRL, 32'h100);
    wt(12);
    `CHK("swap", 2'h1, {hs_gate[0], ls_gate[0]})
    ls_open <= 3'h1;
    wt(5);
    ls_open <= 3'h0;
    wt(12);
    rd(hbfs_pkg::ADDR_OL, 32'h0);
    ls_open <= 3'h1;
    wt(20);
    `CHK("ol_on", 1'h1, ls_gate[0])
    rd(hbfs_pkg::ADDR_GSTAT, 32'h41);
    ls_open <= 3'h0;
    wt(12);
    rd(hbfs_pkg::ADDR_OL, 32'h100);
    rd(hbfs_pkg::ADDR_OL, 32'h0);
    // Low-side overcurrent trips, returns once its flag is read-cleared
    ls_short <= 3'h1;
    wt(14);
    `CHK("ls_oc_gate", 1'h0, ls_gate[0])
    ls_short <= 3'h0;
    rd(hbfs_pkg::ADDR_OC, 32'h100);
    wt(12);
    `CHK("ls_oc_back", 1'h1, ls_gate[0])
    // Unmapped address
    axi(1'h1, 8'h20, 32'h1);
    `CHK("wr_resp", hbfs_pkg::RESP_SLVERR, r)
    axi(1'h0, 8'h20, 32'h0);
    `CHK("rd_resp", {hbfs_pkg::RESP_SLVERR, 32'h0}, {r, q})
    // Reset in mid-run clears all state
    aresetn <= 1'h0;
    wt(2);
    `CHK("rst_stage", 6'h00, {stage_enable, ls_gate})
    aresetn <= 1'h1;
    rd(hbfs_pkg::ADDR_CTRL, 32'h0);
    rd(hbfs_pkg::ADDR_GSTAT, 32'h0);
    conclude();
  end
endmodule : tb_hbfs_top
